//--- design/cisc_ctrl.sv
// Comparator input select and control registers with APB slave.
// Assumes comparator output and capture pin synchronous to clk.
//
// Function
// - Mux enable set and converter off: converter mux drives negative input.
// - Mux enable clear: negative comparator pin drives negative input.
// - Writing power-off one switches comparator off; settable any time.
// - Bandgap select set: bandgap on positive input, else positive pin.
// - Second converter register: mux enable bit 6, trigger field 2:0.
// - Comparator register fields; output read-only, rest reset to zero.
// - Capture select routes comparator output to timer capture trigger.
`timescale 1ns/1ns
`default_nettype none
module cisc_ctrl (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic      [31:0] prdata,
	output logic             pslverr,
	input  wire logic        converterEnable,
	input  wire logic        cmpRawOut,
	input  wire logic        capturePin,
	output logic             negSelMux,
	output logic             posSelBandgap,
	output logic             cmpPowerOff,
	output logic             captureTrigger,
	output logic             cmpIrq,
	output logic             irq
);
	import cisc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	logic [7:0] adcbQ;
	logic [7:0] cmpcsQ;
	logic [1:0] statQ;
	logic [1:0] maskQ;
	logic       wrEn;
	logic       rdEn;
	logic       cmpEvent;
	logic       outQ;
	cisc_edge_if edgeBus ();

	function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
		hit = (a == r);
	endfunction : hit

	assign wrEn    = psel & penable & pwrite;
	assign rdEn    = psel & penable & ~pwrite;
	assign pready  = 1'b1;
	assign pslverr = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// Comparator output is gated low while powered off
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			outQ <= 1'b0;
		end else begin
			outQ <= cmpRawOut & ~cmpcsQ[CMP_OFF_BIT];
		end
	end
	assign edgeBus.cmpOut = outQ;

	cisc_edge_det u_edge (
		.clk     (clk),
		.reset_n (reset_n),
		.edge_io (edgeBus)
	);

	always_comb begin
		unique case (cmpcsQ[1:0])
			MODE_TOGGLE: cmpEvent = edgeBus.rise | edgeBus.fall;
			MODE_FALL:   cmpEvent = edgeBus.fall;
			MODE_RISE:   cmpEvent = edgeBus.rise;
			default:     cmpEvent = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			adcbQ <= ADCB_RESET;
		end else if (wrEn && hit(paddr, CISC_ADDR_ADCB)) begin
			adcbQ <= {1'b0, pwdata[ADCB_MUXEN_BIT], 3'h0, pwdata[2:0]};
		end
	end

	// Flag: set wins over a write-one clear
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cmpcsQ <= CMPCS_RESET;
		end else begin
			if (wrEn && hit(paddr, CISC_ADDR_CMPCS)) begin
				cmpcsQ[7:6] <= pwdata[7:6];
				cmpcsQ[3:0] <= pwdata[3:0];
				if (pwdata[CMP_FLAG_BIT]) begin
					cmpcsQ[CMP_FLAG_BIT] <= 1'b0;
				end
			end
			if (cmpEvent) begin
				cmpcsQ[CMP_FLAG_BIT] <= 1'b1;
			end
			cmpcsQ[CMP_OUT_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			maskQ <= MASK_RESET;
		end else if (wrEn && hit(paddr, CISC_ADDR_IRQMASK)) begin
			maskQ <= pwdata[1:0];
		end
	end

	// Bit 0 comparator event, bit 1 capture source change; read clears
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			statQ <= STAT_RESET;
		end else begin
			if (rdEn && hit(paddr, CISC_ADDR_IRQSTAT)) begin
				statQ <= 2'h0;
			end
			if (cmpEvent) begin
				statQ[0] <= 1'b1;
			end
			if (wrEn && hit(paddr, CISC_ADDR_CMPCS)
			    && (pwdata[CMP_CAP_BIT] != cmpcsQ[CMP_CAP_BIT])) begin
				statQ[1] <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				CISC_ADDR_ADCB:    prdata <= {24'h0, adcbQ};
				CISC_ADDR_CMPCS:   prdata <= {24'h0, cmpcsQ[7:6], outQ,
				                              cmpcsQ[4:0]};
				CISC_ADDR_IRQSTAT: prdata <= {30'h0, statQ};
				CISC_ADDR_IRQMASK: prdata <= {30'h0, maskQ};
				default:           prdata <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Converter enable overrides the mux; power-off order is software's job
	assign negSelMux      = adcbQ[ADCB_MUXEN_BIT] & ~converterEnable;
	assign posSelBandgap  = cmpcsQ[CMP_BG_BIT];
	assign cmpPowerOff    = cmpcsQ[CMP_OFF_BIT];
	assign captureTrigger = cmpcsQ[CMP_CAP_BIT] ? outQ : capturePin;
	assign cmpIrq = cmpcsQ[CMP_FLAG_BIT] & cmpcsQ[CMP_IE_BIT];
	assign irq    = |(statQ & maskQ);
endmodule : cisc_ctrl
`default_nettype wire

//--- design/cisc_pkg.sv
// Constants for the comparator input select and control block.
// Assumes a 32-bit APB register bus and one system clock.
package cisc_pkg;
	localparam logic [11:0] CISC_ADDR_ADCB    = 12'h000;
	localparam logic [11:0] CISC_ADDR_CMPCS   = 12'h004;
	localparam logic [11:0] CISC_ADDR_IRQSTAT = 12'h008;
	localparam logic [11:0] CISC_ADDR_IRQMASK = 12'h00C;
	localparam int ADCB_MUXEN_BIT = 6;
	localparam int CMP_OFF_BIT    = 7;
	localparam int CMP_BG_BIT     = 6;
	localparam int CMP_OUT_BIT    = 5;
	localparam int CMP_FLAG_BIT   = 4;
	localparam int CMP_IE_BIT     = 3;
	localparam int CMP_CAP_BIT    = 2;
	localparam logic [7:0] ADCB_RESET  = 8'h00;
	localparam logic [7:0] CMPCS_RESET = 8'h00;
	localparam logic [1:0] STAT_RESET  = 2'h0;
	localparam logic [1:0] MASK_RESET  = 2'h0;
	// Interrupt mode encodings
	localparam logic [1:0] MODE_TOGGLE = 2'h0;
	localparam logic [1:0] MODE_FALL   = 2'h2;
	localparam logic [1:0] MODE_RISE   = 2'h3;
endpackage : cisc_pkg

//--- design/cisc_edge_if.sv
// Carries the comparator output edge events between the two modules.
// Assumes one system clock.
`timescale 1ns/1ns
`default_nettype none
interface cisc_edge_if;
	logic cmpOut;
	logic rise;
	logic fall;
	modport det (input cmpOut, output rise, output fall);
	modport ctl (output cmpOut, input rise, input fall);
endinterface : cisc_edge_if
`default_nettype wire

//--- design/cisc_edge_det.sv
// Edge detector for the comparator output.
// Assumes cmpOut is already synchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module cisc_edge_det (
	input  wire logic clk,
	input  wire logic reset_n,
	cisc_edge_if.det  edge_io
);
	logic prevQ;
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			prevQ <= 1'b0;
		end else begin
			prevQ <= edge_io.cmpOut;
		end
	end
	assign edge_io.rise = edge_io.cmpOut & ~prevQ;
	assign edge_io.fall = ~edge_io.cmpOut & prevQ;
endmodule : cisc_edge_det
`default_nettype wire

//--- testbench/cisc_ctrl_sva.sv
// Port checker for cisc_ctrl.
// Assumes an APB master that holds each request until pready.
`timescale 1ns/1ns
`default_nettype none
module cisc_ctrl_sva (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        converterEnable,
	input wire logic        capturePin,
	input wire logic        negSelMux,
	input wire logic        posSelBandgap,
	input wire logic        cmpPowerOff,
	input wire logic        captureTrigger,
	input wire logic        cmpIrq
);
	wire acc = psel && penable;
	wire wr0 = acc && pwrite && paddr == 12'h000;
	wire wr4 = acc && pwrite && paddr == 12'h004;
	wire rd0 = acc && !pwrite && paddr == 12'h000;
	wire rd4 = acc && !pwrite && paddr == 12'h004;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	mux_on_a: assert property (wr0 && pwdata[6] ##1 !converterEnable
		|-> negSelMux) else $error("mux not on negative input");
	pin_neg_a: assert property (wr0 && !pwdata[6] |=> !negSelMux)
		else $error("pin not on negative input");
	power_off_a: assert property (wr4 && pwdata[7] |=> cmpPowerOff)
		else $error("power off not taken");
	bandgap_sel_a: assert property (wr4
		|=> posSelBandgap == $past(pwdata[6])) else $error("bandgap");
	conv_read_a: assert property (rd0
		|-> prdata[31:7] == 0 && prdata[5:3] == 0) else $error("reg0");
	ctrl_read_a: assert property (rd4 |-> prdata[31:8] == 0 &&
		prdata[7:6] == {cmpPowerOff, posSelBandgap}) else $error("reg4");
	capture_pin_a: assert property (wr4 && !pwdata[2]
		|=> captureTrigger == capturePin) else $error("capture");
	irq_off_a: assert property (wr4 && !pwdata[3] |=> !cmpIrq)
		else $error("irq while disabled");
	cover property (negSelMux);
	cover property (cmpIrq);
	cover property (rd4 && prdata[7]);
endmodule : cisc_ctrl_sva
bind cisc_ctrl cisc_ctrl_sva u_sva (.*);
`default_nettype wire

//--- testbench/cisc_ctrl_tb.sv
// Bench for cisc_ctrl: registers, input select, interrupt.
// Assumes a zero wait state APB slave.
`timescale 1ns/1ns
`default_nettype none
module cisc_ctrl_tb;
	import cisc_pkg::*;
	logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic converterEnable = 0, cmpRawOut = 0, capturePin = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rd;
	wire pready, pslverr, negSelMux, posSelBandgap, cmpPowerOff;
	wire captureTrigger, cmpIrq, irq;
	wire [31:0] prdata;
	int err_count = 0, samples_checked = 0, cyc = 0;
	always #10 clk = ~clk;
	cisc_ctrl dut (.*);
	task automatic chk(input logic [31:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic w, logic [11:0] a, logic [31:0] d);
		@(posedge clk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		{psel, penable} <= 2'b00;
	endtask : bus
	task automatic rdchk(input logic [11:0] a, logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rdchk
	task automatic t_mux;
		rdchk(CISC_ADDR_ADCB, 32'h0);
		rdchk(CISC_ADDR_CMPCS, 32'h0);
		bus(1'b1, CISC_ADDR_ADCB, 32'hFFFFFFFF);
		@(negedge clk) chk(negSelMux, 1);
		rdchk(CISC_ADDR_ADCB, 32'h47);
		converterEnable <= 1'b1;
		@(negedge clk) chk(negSelMux, 0);
		bus(1'b1, CISC_ADDR_ADCB, 32'h0);
		converterEnable <= 1'b0;
		@(negedge clk) chk(negSelMux, 0);
		$display("mux test done");
	endtask : t_mux
	task automatic t_irq;
		capturePin <= 1'b1;
		bus(1'b1, CISC_ADDR_CMPCS, 32'hC3);
		@(negedge clk) chk({cmpPowerOff, posSelBandgap, captureTrigger}, 7);
		rdchk(CISC_ADDR_CMPCS, 32'hC3);
		bus(1'b1, CISC_ADDR_IRQMASK, 32'h1);
		bus(1'b1, CISC_ADDR_CMPCS, 32'h03);
		bus(1'b1, CISC_ADDR_CMPCS, 32'h0B);
		cmpRawOut <= 1'b1;
		repeat (3) @(posedge clk);
		@(negedge clk) chk({cmpIrq, irq}, 3);
		rdchk(CISC_ADDR_IRQSTAT, 32'h1);
		@(negedge clk) chk(irq, 0);
		rdchk(CISC_ADDR_CMPCS, 32'h3B);
		bus(1'b1, CISC_ADDR_CMPCS, 32'h13);
		@(negedge clk) chk(cmpIrq, 0);
		rdchk(12'h010, 32'h0);
		$display("control test done");
	endtask : t_irq
	task automatic t_cap;
		capturePin <= 1'b0;
		bus(1'b1, CISC_ADDR_CMPCS, 32'h07);
		@(negedge clk) chk(captureTrigger, 1);
		rdchk(CISC_ADDR_IRQSTAT, 32'h2);
		bus(1'b1, CISC_ADDR_CMPCS, 32'h06);
		cmpRawOut <= 1'b0;
		repeat (3) @(posedge clk);
		@(negedge clk) chk(captureTrigger, 0);
		rdchk(CISC_ADDR_CMPCS, 32'h16);
		bus(1'b1, CISC_ADDR_CMPCS, 32'h14);
		cmpRawOut <= 1'b1;
		repeat (3) @(posedge clk);
		rdchk(CISC_ADDR_CMPCS, 32'h34);
		chk({pready, pslverr}, 2);
		$display("capture test done");
	endtask : t_cap
	task automatic close_out;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			err_count++;
			close_out();
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		t_mux();
		t_irq();
		t_cap();
		close_out();
	end
endmodule : cisc_ctrl_tb
`default_nettype wire
